// File: pkg/epp_params.svh
// Behaviour
// - Guard bits set at reset; normal modes clear them only in first 64 cycles.
// - Writing ones to guard bits is accepted at any time.
// - Test or bootstrap modes lift the early-window limit on the guard register.
// - Array is mapped only while the map enable bit of configuration is set.
// - Mass erase guard blocks bulk and row erase; clear lets bulk erase proceed.
// - Low voltage guard enable is stored only; inhibit status always reads zero.
// - Five region bits guard 32, 64, 128, 288, 128 byte regions ascending.
// - Pump clock select picks E clock at 0 and RC oscillator at 1.
// - Marked option fields take one write in first 64 cycles normally, any in special.
// - With latch set, a write to the array latches its address and data.
// - While high voltage is on, array writes cannot alter latched address or data.
// - Software waits 10 ms then writes zero; voltage drops and reads resume.
// - Configuration cells may be programmed or erased in any mode when unguarded.
// - Configuration guard set refuses any program or erase of configuration.
// - Configuration takes a single write normally and unlimited writes in special modes.
// - Security enabled with security disable at 0 restricts to single-chip modes.
// - One control write setting both latch and high voltage while the latch is clear sets neither.
// - Byte bit selects byte erase; else row bit selects 16-byte row or all 640.
// - With latch clear, array reads behave as plain read-only memory.
`ifndef EPP_PARAMS_SVH
`define EPP_PARAMS_SVH
`define EPP_OFS_OPTION 8'h39
`define EPP_OFS_PROG 8'h3B
`define EPP_OFS_GUARD 8'h35
`define EPP_OFS_CONFIG 8'h3F
`define EPP_OPTION_RESET 8'h10
`define EPP_GUARD_RESET 8'h1F
`define EPP_OPTION_ONCE_MASK 8'h27
`define EPP_OPTION_FREE_MASK 8'hD8
`define EPP_GUARD_MASK 8'hDF
`define EPP_CONFIG_DEFAULT 8'h0F
`define EPP_BIT_PUMP_CLOCK_SELECT 3
`define EPP_BIT_BYTE 4
`define EPP_BIT_ROW 3
`define EPP_BIT_ERASE 2
`define EPP_BIT_LATCH 1
`define EPP_BIT_HV 0
`define EPP_BIT_LOW_VOLTAGE_INHIBIT_STATUS 6
`define EPP_BIT_MASSG 7
`define EPP_BIT_LVEN 6
`define EPP_BIT_CFGG 4
`define EPP_BIT_MAPEN 0
`define EPP_BIT_SECURITY_DISABLE 3
`define EPP_EARLY_CYCLES 7'd64
`define EPP_ARRAY_BYTES 640
`define EPP_ARRAY_BASE 12'hD80
`define EPP_R0_END 12'hDA0
`define EPP_R1_END 12'hDE0
`define EPP_R2_END 12'hE60
`define EPP_R3_END 12'hF80
`define EPP_ROW_BYTES 16
`endif

// File: pkg/epp_pkg.sv
package epp_pkg;
    // Bus request carried from the CPU side.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } epp_req_t;
    // Operation decoded from the latched sequence.
    typedef enum logic [1:0] {EPP_OP_PROG, EPP_OP_BYTE, EPP_OP_ROW, EPP_OP_BULK} epp_op_t;
    // Programming sequence state.
    typedef enum logic [1:0] {EPP_IDLE, EPP_LATCHED, EPP_HIGHV} epp_state_t;
endpackage : epp_pkg

// File: rtl/epp_early_window.sv
`timescale 1ns/1ps
`include "epp_params.svh"
module epp_early_window (
    input wire logic mclk,
    input wire logic reset,
    output logic open_window
);
    logic [6:0] count;
    // Counts E-clock cycles after reset and holds the early-write window open for 64 of them.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            count <= 7'h00;
            open_window <= 1'b1;
        end
        else
        begin
            if (count != `EPP_EARLY_CYCLES)
                count <= count + 7'h01;
            open_window <= (count + 7'h01) < `EPP_EARLY_CYCLES;
        end
    end
endmodule : epp_early_window

// File: rtl/epp_array.sv
`timescale 1ns/1ps
module epp_array (
    input wire logic mclk,
    input wire logic [9:0] raddr,
    output logic [7:0] rdata,
    input wire logic we,
    input wire logic [9:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] wmask
);
    logic [7:0] mem [0:639];
    // Registered read port; a write ANDs cleared bits (programming) or sets bits (erase via mask ones).
    always_ff @(posedge mclk)
    begin
        rdata <= mem[raddr];
        if (we)
            mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
    end
endmodule : epp_array

// File: rtl/epp_top.sv
`timescale 1ns/1ps
`include "epp_params.svh"
module epp_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic special_mode,
    input wire logic security_option,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic pump_clock_select,
    output logic high_voltage_on,
    output logic single_chip_only,
    output logic eeprom_map_enable
);
    epp_pkg::epp_req_t req;
    epp_pkg::epp_state_t state;
    epp_pkg::epp_state_t next_state;
    logic [7:0] system_options_register;
    logic [7:0] eeprom_block_protect;
    // Configuration cells keep their value across reset; the declaration gives the unprogrammed image.
    logic [7:0] nonvolatile_system_config = `EPP_CONFIG_DEFAULT;
    logic [7:0] eeprom_prog_control;
    logic option_written;
    logic config_written;
    logic [3:0] base_page;
    logic [11:0] lat_addr;
    logic [7:0] lat_data;
    logic lat_is_cfg;
    logic open_window;
    logic [7:0] arr_rdata;
    // Read path and array write port.
    logic rd_arr_q;
    logic [7:0] reg_rdata_q;
    logic arr_we;
    logic [9:0] arr_waddr;
    logic [7:0] arr_wdata;
    logic [7:0] arr_wmask;
    logic [9:0] row_cnt;
    logic bulk_run;
    // Row sweeps keep their scope, because the clearing write wipes the control bits.
    logic sweep_row;

    // Bus request bundle and the fixed page that holds the array.
    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
    assign base_page = 4'hB;

    // Decodes a 12-bit array offset into its guarding region index.
    function automatic logic [2:0] region_of(input logic [11:0] a);
        if (a < `EPP_R0_END)
            region_of = 3'h0;
        else if (a < `EPP_R1_END)
            region_of = 3'h1;
        else if (a < `EPP_R2_END)
            region_of = 3'h2;
        else if (a < `EPP_R3_END)
            region_of = 3'h3;
        else
            region_of = 3'h4;
    endfunction : region_of

    // Returns the array index of an offset within the window.
    function automatic logic [9:0] index_of(input logic [11:0] a);
        logic [11:0] d;
        d = a - `EPP_ARRAY_BASE;
        index_of = d[9:0];
    endfunction : index_of

    // Register and array address decode.
    wire hit_option = req.addr[15:8] == 8'h00 && req.addr[7:0] == `EPP_OFS_OPTION;
    wire hit_prog = req.addr[15:8] == 8'h00 && req.addr[7:0] == `EPP_OFS_PROG;
    wire hit_guard = req.addr[15:8] == 8'h00 && req.addr[7:0] == `EPP_OFS_GUARD;
    wire hit_config = req.addr[15:8] == 8'h00 && req.addr[7:0] == `EPP_OFS_CONFIG;
    wire map_on = nonvolatile_system_config[`EPP_BIT_MAPEN];
    wire hit_array = map_on && req.addr[15:12] == base_page && req.addr[11:0] >= `EPP_ARRAY_BASE;
    // Control bit views and guard lookups for the latched target.
    wire latch_bit = eeprom_prog_control[`EPP_BIT_LATCH];
    wire hv_bit = eeprom_prog_control[`EPP_BIT_HV];
    wire early_ok = open_window || special_mode;
    wire [2:0] lat_region = region_of(lat_addr);
    wire region_guarded = eeprom_block_protect[lat_region];
    // Erase scope from the byte and row bits.
    wire do_byte = eeprom_prog_control[`EPP_BIT_BYTE];
    wire do_row = !do_byte && eeprom_prog_control[`EPP_BIT_ROW];
    wire do_bulk = !do_byte && !eeprom_prog_control[`EPP_BIT_ROW];
    wire is_erase = eeprom_prog_control[`EPP_BIT_ERASE];
    wire mass_blocked = eeprom_block_protect[`EPP_BIT_MASSG] && (do_row || do_bulk);
    wire cfg_blocked = eeprom_block_protect[`EPP_BIT_CFGG];
    // Control writes; a combined latch and voltage write is refused while the latch is still clear.
    wire prog_wr = req.wr && hit_prog;
    wire both_set = req.wdata[`EPP_BIT_LATCH] && req.wdata[`EPP_BIT_HV] && !latch_bit;
    wire hv_allowed = latch_bit && state == epp_pkg::EPP_LATCHED;
    wire [7:0] prog_wval = both_set ? (req.wdata & 8'h3C) : req.wdata;
    wire hv_start = prog_wr && !both_set && req.wdata[`EPP_BIT_HV] && hv_allowed;
    wire hv_stop = prog_wr && !req.wdata[`EPP_BIT_HV] && hv_bit;
    wire capture = req.wr && latch_bit && !hv_bit && (hit_array || hit_config);
    // Configuration commits stop after one program commit in normal modes; erases do not count.
    wire cfg_free = special_mode || !config_written;

    // Commit the operation when high voltage is removed, unless its target is guarded.
    wire commit = hv_stop && state == epp_pkg::EPP_HIGHV;
    wire commit_cfg = commit && lat_is_cfg && !cfg_blocked && cfg_free;
    wire commit_arr = commit && !lat_is_cfg && !(is_erase && mass_blocked)
        && (!region_guarded || (is_erase && !do_byte));

    // Array write port selection: byte write or erase, else a bulk/row sweep.
    // A sweep skips bytes whose region guard is set, so guarded regions survive row and bulk erase.
    wire [11:0] sweep_ofs = `EPP_ARRAY_BASE + {2'b00, row_cnt};
    wire sweep_guarded = eeprom_block_protect[region_of(sweep_ofs)];
    assign arr_we = (commit_arr && (!is_erase || do_byte)) || (bulk_run && !sweep_guarded);
    assign arr_waddr = bulk_run ? row_cnt : index_of(lat_addr);
    assign arr_wdata = (is_erase || bulk_run) ? 8'hFF : 8'h00;
    assign arr_wmask = (is_erase || bulk_run) ? 8'hFF : ~lat_data;

    // Sequence state moves on latch set, high voltage set and the final clearing write.
    always_comb
    begin
        next_state = state;
        unique case (state)
            epp_pkg::EPP_IDLE:
                if (prog_wr && prog_wval[`EPP_BIT_LATCH])
                    next_state = epp_pkg::EPP_LATCHED;
            epp_pkg::EPP_LATCHED:
                if (hv_start)
                    next_state = epp_pkg::EPP_HIGHV;
                else if (prog_wr && !prog_wval[`EPP_BIT_LATCH])
                    next_state = epp_pkg::EPP_IDLE;
            epp_pkg::EPP_HIGHV:
                if (hv_stop)
                    next_state = prog_wval[`EPP_BIT_LATCH] ? epp_pkg::EPP_LATCHED : epp_pkg::EPP_IDLE;
        endcase
    end

    // Control register and sequence state.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state <= epp_pkg::EPP_IDLE;
            eeprom_prog_control <= 8'h00;
        end
        else
        begin
            state <= next_state;
            if (prog_wr && hv_bit && !hv_stop)
                eeprom_prog_control <= eeprom_prog_control;
            else if (prog_wr)
                eeprom_prog_control <= {1'b0, 1'b0, prog_wval[5:1], prog_wval[0] && hv_allowed};
        end
    end

    // Guard register: ones at reset, clears only early in normal modes, sets always.
    always_ff @(posedge mclk)
    begin
        if (reset)
            eeprom_block_protect <= `EPP_GUARD_RESET | 8'h90;
        else if (req.wr && hit_guard)
        begin
            if (early_ok)
                eeprom_block_protect <= req.wdata & `EPP_GUARD_MASK;
            else
                eeprom_block_protect <= eeprom_block_protect | (req.wdata & `EPP_GUARD_MASK);
        end
    end

    // Option register with write-once fields in normal modes.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            system_options_register <= `EPP_OPTION_RESET;
            option_written <= 1'b0;
        end
        else if (req.wr && hit_option)
        begin
            option_written <= 1'b1;
            if (special_mode || (open_window && !option_written))
                system_options_register <= req.wdata;
            else
                system_options_register <= (system_options_register & `EPP_OPTION_ONCE_MASK)
                    | (req.wdata & `EPP_OPTION_FREE_MASK);
        end
    end

    // Configuration cells are nonvolatile: reset leaves them alone, only commits change them.
    always_ff @(posedge mclk)
    begin
        if (reset)
            config_written <= 1'b0;
        else if (commit_cfg)
        begin
            config_written <= !is_erase;
            if (is_erase)
                nonvolatile_system_config <= 8'hFF;
            else
                nonvolatile_system_config <= nonvolatile_system_config & lat_data;
        end
    end

    // Address and data latch, frozen while high voltage is on.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            lat_addr <= `EPP_ARRAY_BASE;
            lat_data <= 8'hFF;
            lat_is_cfg <= 1'b0;
        end
        else if (capture)
        begin
            lat_addr <= hit_config ? `EPP_ARRAY_BASE : req.addr[11:0];
            lat_data <= req.wdata;
            lat_is_cfg <= hit_config;
        end
    end

    // Row and bulk erase sweep through the array one byte per cycle.
    // First byte of the row that holds the latched address.
    wire [9:0] row_first = index_of(lat_addr) & 10'h3F0;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            bulk_run <= 1'b0;
            sweep_row <= 1'b0;
            row_cnt <= 10'h000;
        end
        else if (commit_arr && is_erase && !do_byte)
        begin
            bulk_run <= 1'b1;
            sweep_row <= do_row;
            row_cnt <= do_row ? row_first : 10'h000;
        end
        else if (bulk_run)
        begin
            row_cnt <= row_cnt + 10'h001;
            if ((sweep_row && row_cnt[3:0] == 4'hF) || row_cnt == 10'(`EPP_ARRAY_BYTES - 1))
                bulk_run <= 1'b0;
        end
    end

    // Counter that times the early write window after reset.
    epp_early_window u_window (
        .mclk(mclk),
        .reset(reset),
        .open_window(open_window)
    );

    // Array cells with a registered read port.
    epp_array u_array (
        .mclk(mclk),
        .raddr(index_of(req.addr[11:0])),
        .rdata(arr_rdata),
        .we(arr_we),
        .waddr(arr_waddr),
        .wdata(arr_wdata),
        .wmask(arr_wmask)
    );

    // Register read data, captured alongside the strobe; low voltage inhibit reads zero.
    wire [7:0] reg_sel = hit_option ? system_options_register
        : hit_prog ? (eeprom_prog_control & ~(8'h01 << `EPP_BIT_LOW_VOLTAGE_INHIBIT_STATUS))
        : hit_guard ? eeprom_block_protect
        : hit_config ? nonvolatile_system_config : 8'h00;
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rd_arr_q <= 1'b0;
            reg_rdata_q <= 8'h00;
        end
        else
        begin
            rd_arr_q <= req.rd && hit_array && !latch_bit;
            reg_rdata_q <= req.rd ? reg_sel : 8'h00;
        end
    end
    // Array data win only after an array read; the register path is zero then.
    assign bus_rdata = rd_arr_q ? arr_rdata : reg_rdata_q;

    // Status outputs registered from control state.
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pump_clock_select <= 1'b0;
            high_voltage_on <= 1'b0;
            single_chip_only <= 1'b0;
            eeprom_map_enable <= 1'b0;
        end
        else
        begin
            pump_clock_select <= system_options_register[`EPP_BIT_PUMP_CLOCK_SELECT];
            high_voltage_on <= hv_bit;
            single_chip_only <= security_option && !nonvolatile_system_config[`EPP_BIT_SECURITY_DISABLE];
            eeprom_map_enable <= map_on;
        end
    end
endmodule : epp_top

// File: tb/epp_top_sva.sv
`timescale 1ns/1ps
module epp_top_sva (
    input wire logic mclk,
    input wire logic reset,
    input wire logic security_option,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic pump_clock_select,
    input wire logic high_voltage_on,
    input wire logic single_chip_only
);
    // Decoded writes to the control and option registers.
    wire prg_wr = bus_wr && (bus_addr == 16'h003B);
    wire hv_cmd = prg_wr && bus_wdata[0];
    wire clr_cmd = prg_wr && (bus_wdata == 8'h00);
    wire pair_cmd = prg_wr && (bus_wdata[1:0] == 2'b11);
    wire opt_wr = bus_wr && (bus_addr == 16'h0039);
    logic lat_seen;
    logic pump_clock_select_exp;

    // Tracks whether the last control write left the latch bit set.
    always_ff @(posedge mclk)
    begin
        if (reset)
            lat_seen <= 1'b0;
        else if (prg_wr && (bus_wdata[1:0] != 2'b11))
            lat_seen <= bus_wdata[1];
    end

    // Remembers the clock select that software wrote last.
    always_ff @(posedge mclk)
    begin
        if (reset)
            pump_clock_select_exp <= 1'b0;
        else if (opt_wr)
            pump_clock_select_exp <= bus_wdata[3];
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);

    // Latch and voltage requested in one write must not switch the voltage on.
    a_pair_refused: assert property (pair_cmd && !lat_seen && !high_voltage_on |=> !high_voltage_on ##1 !high_voltage_on)
        else $error("high voltage rose from a combined latch and voltage write");
    a_hv_from_write: assert property ($rose(high_voltage_on) |-> $past(hv_cmd) || $past(hv_cmd, 2))
        else $error("high voltage rose without a voltage command");
    a_hv_clear_drop: assert property (high_voltage_on && clr_cmd |-> ##[1:2] !high_voltage_on)
        else $error("high voltage stayed on after the clearing write");
    a_hv_holds: assert property (high_voltage_on && hv_cmd |=> high_voltage_on)
        else $error("high voltage dropped on a repeated voltage command");
    a_pump_clock_select_follow: assert property (opt_wr |-> ##2 pump_clock_select == pump_clock_select_exp)
        else $error("pump clock select does not follow the option write");
    a_pump_hold: assert property ($changed(pump_clock_select) |-> $past(opt_wr) || $past(opt_wr, 2))
        else $error("pump clock select moved without an option write");
    a_secure_option: assert property ((!security_option) [*3] |-> !single_chip_only)
        else $error("single chip restriction without the security option");
    a_low_voltage_inhibit_status_zero: assert property (bus_rd && (bus_addr == 16'h003B) |=> !bus_rdata[6])
        else $error("inhibit status read back as one");
endmodule : epp_top_sva

bind epp_top epp_top_sva i_epp_top_sva (.mclk(mclk), .reset(reset), .security_option(security_option),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pump_clock_select(pump_clock_select), .high_voltage_on(high_voltage_on), .single_chip_only(single_chip_only));

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "epp_params.svh"
module tb_top;
    localparam logic [15:0] A_OPT = {8'h00, `EPP_OFS_OPTION};
    localparam logic [15:0] A_GRD = {8'h00, `EPP_OFS_GUARD};
    localparam logic [15:0] A_PRG = {8'h00, `EPP_OFS_PROG};
    localparam logic [15:0] A_CFG = {8'h00, `EPP_OFS_CONFIG};
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic special_mode = 1'b0;
    logic security_option = 1'b0;
    epp_pkg::epp_req_t req = '0;
    logic [7:0] bus_rdata;
    logic pump_clock_select;
    logic high_voltage_on;
    logic single_chip_only;
    logic eeprom_map_enable;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    string name_q[$];
    int fail_count = 0;
    int n_compared = 0;
    logic [7:0] v;

    // Block under test.
    epp_top i_epp_top (.mclk(mclk), .reset(reset), .special_mode(special_mode), .security_option(security_option),
        .bus_addr(req.addr), .bus_wdata(req.wdata), .bus_wr(req.wr), .bus_rd(req.rd), .bus_rdata(bus_rdata),
        .pump_clock_select(pump_clock_select), .high_voltage_on(high_voltage_on),
        .single_chip_only(single_chip_only), .eeprom_map_enable(eeprom_map_enable));

    // Clock at 25 MHz.
    initial
    begin
        forever #20 mclk = ~mclk;
    end

    // Compares one value and counts the result.
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // One-cycle write strobe; the gap cycle keeps strobes from being reassigned in one step.
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr

    // One-cycle read strobe; the expected byte is noted for the monitor.
    task rd(input logic [15:0] a, input logic [7:0] e, input string what);
        @(posedge mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        name_q.push_back(what);
        @(posedge mclk);
        req.rd <= 1'b0;
    endtask : rd

    // Full latch, load, voltage, clear sequence with a stray write while the voltage is on.
    task op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] ctl);
        wr(A_PRG, ctl & 8'hFE);
        wr(a, d);
        wr(A_PRG, ctl);
        wr(A_PRG, ctl);
        wr(a + 16'h0001, 8'h00);
        wr(A_PRG, 8'h00);
        repeat (2) @(posedge mclk);
    endtask : op

    // Lets registered outputs settle before they are sampled.
    task settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask : settle

    // Holds reset for twelve cycles in the chosen mode.
    task do_reset(input logic special);
        special_mode <= special;
        reset <= 1'b1;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
    endtask : do_reset

    // Read data stand only in the cycle after the strobe; compare the oldest note there.
    always @(posedge mclk) rd_q <= req.rd;
    always @(negedge mclk)
    begin
        if (rd_q && exp_q.size() > 0)
            check(name_q.pop_front(), bus_rdata, exp_q.pop_front());
    end

    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end

    // Main sequence: normal mode first, then special mode.
    initial
    begin
        void'($urandom(32'h87B2631A));
        do_reset(1'b0);
        rd(A_OPT, `EPP_OPTION_RESET, "option reset");
        rd(A_GRD, 8'h9F, "guard reset");
        rd(A_PRG, 8'h00, "control reset");
        rd(A_CFG, `EPP_CONFIG_DEFAULT, "config initial");
        wr(A_OPT, 8'hFF);
        wr(A_OPT, 8'h00);
        rd(A_OPT, `EPP_OPTION_ONCE_MASK, "option once fields");
        wr(A_GRD, 8'h80);
        rd(A_GRD, 8'h80, "guard early clear");
        op(16'hBD80, 8'h00, 8'h17);
        op(16'hBD80, 8'h3C, 8'h03);
        rd(16'hBD80, 8'h3C, "region 0 byte");
        repeat (30) @(posedge mclk);
        wr(A_GRD, 8'h00);
        rd(A_GRD, 8'h80, "guard late clear");
        wr(A_GRD, 8'h81);
        rd(A_GRD, 8'h81, "guard set again");
        op(16'hBD80, 8'h00, 8'h17);
        rd(16'hBD80, 8'h3C, "guarded region 0");
        op(16'hBDA0, 8'h00, 8'h17);
        rd(16'hBDA0, 8'hFF, "byte erased");
        op(16'hBDA0, 8'h5A, 8'h03);
        rd(16'hBDA0, 8'h5A, "programmed byte");
        op(16'hBDA0, 8'h00, 8'h0F);
        repeat (20) @(posedge mclk);
        rd(16'hBDA0, 8'h5A, "row erase refused");
        security_option <= 1'b1;
        op(A_CFG, 8'h00, 8'h17);
        rd(A_CFG, 8'hFF, "config erased");
        op(A_CFG, 8'h07, 8'h03);
        rd(A_CFG, 8'h07, "config programmed");
        settle();
        check("single chip", {7'h00, single_chip_only}, 8'h01);
        op(A_CFG, 8'h01, 8'h03);
        rd(A_CFG, 8'h07, "config second write");
        wr(A_GRD, 8'h91);
        op(A_CFG, 8'h00, 8'h17);
        rd(A_CFG, 8'h07, "config guarded");
        wr(A_PRG, 8'h03);
        rd(A_PRG, 8'h00, "latch with voltage");
        security_option <= 1'b0;
        do_reset(1'b1);
        repeat (80) @(posedge mclk);
        wr(A_GRD, 8'h40);
        rd(A_GRD, 8'h40, "guard special");
        rd(A_PRG, 8'h00, "inhibit status");
        wr(A_GRD, 8'h00);
        rd(A_GRD, 8'h00, "guard rewrite");
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            wr(A_OPT, v);
            rd(A_OPT, v, "option special");
        end
        settle();
        check("pump clock", {7'h00, pump_clock_select}, {7'h00, v[`EPP_BIT_PUMP_CLOCK_SELECT]});
        op(16'hBDA0, 8'h00, 8'h07);
        repeat (700) @(posedge mclk);
        rd(16'hBD80, 8'hFF, "bulk erased low");
        rd(16'hBFFF, 8'hFF, "bulk erased high");
        v = 8'($urandom);
        op(16'hBE00, v, 8'h03);
        rd(16'hBE00, v, "random program");
        op(A_CFG, 8'h05, 8'h03);
        op(A_CFG, 8'h01, 8'h03);
        rd(A_CFG, 8'h01, "config special rewrite");
        settle();
        check("map enable", {7'h00, eeprom_map_enable}, 8'h01);
        op(A_CFG, 8'h00, 8'h03);
        settle();
        check("map disable", {7'h00, eeprom_map_enable}, 8'h00);
        rd(16'hBD80, 8'h00, "unmapped array");
        settle();
        check("reads left", 8'(exp_q.size()), 8'h00);
        end_of_test();
    end
endmodule : tb_top
